// *** design/rx_filter.sv ***
// Receive address filter, pad strip, FCS check, fragment deletion and collision test check.
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - On AUI, missing collision test within 40 bit times of receive idle sets error flag.
// - Twisted-pair mode skips that check; error flag set after transmit during link fail.
// - Collision error never drives the interrupt; it sets the summary error bit.
// - First destination bit 0 means unicast, 1 means multicast.
// - All-ones destination address is broadcast, handled separately.
// - Unicast accepted only when destination equals the 6-byte station address, or when promiscuous bit 15 is set.
// - First received byte compares with address bits 7:0, sixth with 47:40.
// - Disable-unicast bit 13 rejects all unicast frames unless promiscuous bit 15 is set.
// - Multicast acceptance comes from the logical filter; all zeros accepts none.
// - Broadcast always accepted unless disable-broadcast bit 14 is set.
// - Promiscuous bit 15 accepts every frame, overriding both disable bits.
// - Promiscuous frames still obey the minimum length check.
// - Receive watermark sets drain threshold; reset value 10b means 64 bytes.
// - Pad strip enable bit 0 removes pad and FCS before the FIFO.
// - Strip only when length field below 46, keeping that many data bytes.
// - FCS checked over all received bytes including stripped pad; mismatch flags error.
// - Frames colliding within 512 bit times of start are deleted from the FIFO.
// - Frames shorter than 64 bytes are deleted unless runt accept is set.
// - Deletion works whether or not earlier frames wait in the FIFO.
// - Logical filter is 64 bits and hashing shares the single FCS generator.
module rx_filter
  import rx_filter_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_col,
  output logic             fifo_wr,
  output logic      [7:0]  fifo_data,
  output logic             fifo_end,
  output logic             fifo_keep,
  output logic             crc_error,
  input  wire logic [7:0]  fifo_level,
  output logic             drain_request,
  input  wire logic        tx_active,
  input  wire logic        rx_carrier,
  input  wire logic        sqe_in,
  input  wire logic        tp_mode,
  input  wire logic        link_fail,
  output logic             interrupt_out
);

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic [15:0] mode_reg;
    logic [47:0] station_address;
    logic [63:0] logical_multicast_filter;
    logic        pad_strip_enable;
    logic [1:0]  receive_watermark;
    logic        runt_accept_enable;
    logic        collision_error_flag;
    logic        in_frame;
    logic [10:0] idx;
    logic [31:0] crc;
    logic        multicast;
    logic        all_ones;
    logic        ucast_match;
    logic        hash_hit;
    logic [15:0] len_field;
    logic        strip_active;
    logic        fragment;
    logic        fifo_wr;
    logic [7:0]  fifo_data;
    logic        fifo_end;
    logic        fifo_keep;
    logic        crc_error;
    logic        drain_request;
    sqe_state_t  sqe_state;
    logic [7:0]  sqe_count;
    logic        interrupt_out;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Serial FCS update, bit 0 of each byte first as on the wire.
  function automatic logic [31:0] crc_byte(input logic [31:0] crc_in, input logic [7:0] d);
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (c[31] ^ d[i]) begin
        c = {c[30:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[30:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Merges a bus write into a 32-bit register under byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] watermark_bytes(input logic [1:0] w);
    case (w)
      2'h0:    return WATERMARK_BYTES_0;
      2'h1:    return WATERMARK_BYTES_1;
      2'h2:    return WATERMARK_BYTES_2;
      default: return WATERMARK_BYTES_3;
    endcase
  endfunction

  always_comb begin
    logic [31:0] rd;
    logic [31:0] wv;
    logic        collision_error_flag_set;
    logic        collision_error_flag_clr;
    logic        accept;
    logic        runt;
    logic [31:0] crc_next;
    logic [7:0]  sta_byte;
    logic [10:0] keep_bytes;
    rd         = 32'h0000_0000;
    wv         = 32'h0000_0000;
    collision_error_flag_set   = 1'b0;
    collision_error_flag_clr   = 1'b0;
    accept     = 1'b0;
    runt       = 1'b0;
    crc_next   = 32'h0000_0000;
    sta_byte   = 8'h00;
    keep_bytes = 11'h000;
    s_d        = s_q;

    // Register bus: one wait cycle, then the answer stands for the accepting edge.
    case (avs_address)
      OFS_MAIN_CONTROL_STATUS: begin
        rd[MCS_COLLISION_ERROR_BIT] = s_q.collision_error_flag;
        rd[MCS_ERROR_SUMMARY_BIT]   = s_q.collision_error_flag;
      end
      OFS_MODE_REG:        rd = {16'h0000, s_q.mode_reg};
      OFS_STATION_LO:      rd = s_q.station_address[31:0];
      OFS_STATION_HI:      rd = {16'h0000, s_q.station_address[47:32]};
      OFS_FILTER_LO:       rd = s_q.logical_multicast_filter[31:0];
      OFS_FILTER_HI:       rd = s_q.logical_multicast_filter[63:32];
      OFS_FEATURE_CONTROL: rd[FEATURE_PAD_STRIP_BIT] = s_q.pad_strip_enable;
      OFS_FIFO_THRESHOLD:  rd[1:0] = s_q.receive_watermark;
      OFS_TEST_FEATURE:    rd[TEST_RUNT_ACCEPT_BIT] = s_q.runt_accept_enable;
      default:             rd = 32'h0000_0000;
    endcase

    if ((avs_read || avs_write) && s_q.waitrequest) begin
      s_d.waitrequest = 1'b0;
      s_d.readdata    = avs_read ? rd : 32'h0000_0000;
    end else begin
      s_d.waitrequest = 1'b1;
    end

    if (avs_write && !s_q.waitrequest) begin
      case (avs_address)
        OFS_MAIN_CONTROL_STATUS: begin
          collision_error_flag_clr = avs_byteenable[0] && avs_writedata[MCS_COLLISION_ERROR_BIT];
        end
        OFS_MODE_REG: begin
          wv = merge({16'h0000, s_q.mode_reg}, avs_writedata, avs_byteenable);
          s_d.mode_reg = wv[15:0];
        end
        OFS_STATION_LO: begin
          s_d.station_address[31:0] = merge(s_q.station_address[31:0], avs_writedata, avs_byteenable);
        end
        OFS_STATION_HI: begin
          wv = merge({16'h0000, s_q.station_address[47:32]}, avs_writedata, avs_byteenable);
          s_d.station_address[47:32] = wv[15:0];
        end
        OFS_FILTER_LO: begin
          s_d.logical_multicast_filter[31:0] =
            merge(s_q.logical_multicast_filter[31:0], avs_writedata, avs_byteenable);
        end
        OFS_FILTER_HI: begin
          s_d.logical_multicast_filter[63:32] =
            merge(s_q.logical_multicast_filter[63:32], avs_writedata, avs_byteenable);
        end
        OFS_FEATURE_CONTROL: begin
          if (avs_byteenable[0]) begin
            s_d.pad_strip_enable = avs_writedata[FEATURE_PAD_STRIP_BIT];
          end
        end
        OFS_FIFO_THRESHOLD: begin
          if (avs_byteenable[0]) begin
            s_d.receive_watermark = avs_writedata[1:0];
          end
        end
        OFS_TEST_FEATURE: begin
          if (avs_byteenable[0]) begin
            s_d.runt_accept_enable = avs_writedata[TEST_RUNT_ACCEPT_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // Collision test check after each transmission.
    case (s_q.sqe_state)
      SQ_IDLE: begin
        if (tx_active) begin
          s_d.sqe_state = SQ_TX;
        end
      end
      SQ_TX: begin
        if (!tx_active) begin
          if (tp_mode) begin
            collision_error_flag_set      = link_fail;
            s_d.sqe_state = SQ_IDLE;
          end else if (sqe_in) begin
            s_d.sqe_state = SQ_IDLE;
          end else begin
            s_d.sqe_state = SQ_WAIT_IDLE;
          end
        end
      end
      SQ_WAIT_IDLE: begin
        s_d.sqe_count = 8'h00;
        if (sqe_in) begin
          s_d.sqe_state = SQ_IDLE;
        end else if (!rx_carrier) begin
          s_d.sqe_state = SQ_WINDOW;
        end
      end
      SQ_WINDOW: begin
        if (sqe_in) begin
          s_d.sqe_state = SQ_IDLE;
        end else if (s_q.sqe_count >= SQE_WINDOW_CYC - 8'h01) begin
          collision_error_flag_set      = 1'b1;
          s_d.sqe_state = SQ_IDLE;
        end else begin
          s_d.sqe_count = s_q.sqe_count + 8'h01;
        end
      end
      default: s_d.sqe_state = SQ_IDLE;
    endcase

    // A new event wins over a clear in the same cycle.
    if (collision_error_flag_set) begin
      s_d.collision_error_flag = 1'b1;
    end else if (collision_error_flag_clr) begin
      s_d.collision_error_flag = 1'b0;
    end
    // The interrupt line is never driven by the collision error.
    s_d.interrupt_out = 1'b0;

    s_d.drain_request = fifo_level >= watermark_bytes(s_q.receive_watermark);

    // Receive byte path.
    s_d.fifo_wr  = 1'b0;
    s_d.fifo_end = 1'b0;
    if (s_q.in_frame && rx_col && s_q.idx < SLOT_BYTES) begin
      s_d.fragment = 1'b1;
    end
    if (rx_valid) begin
      if (!s_q.in_frame) begin
        s_d.in_frame     = 1'b1;
        s_d.idx          = 11'h000;
        s_d.crc          = crc_byte(CRC_INIT, rx_data);
        s_d.multicast    = rx_data[0];
        s_d.all_ones     = rx_data == 8'hff;
        s_d.ucast_match  = rx_data == s_q.station_address[7:0];
        s_d.strip_active = 1'b0;
        s_d.fragment     = rx_col;
        s_d.hash_hit     = 1'b0;
        crc_next         = s_d.crc;
      end else begin
        crc_next = crc_byte(s_q.crc, rx_data);
        s_d.crc  = crc_next;
        if (s_q.idx < DA_BYTES - 11'h001) begin
          sta_byte        = s_q.station_address[8*(s_q.idx + 11'h001) +: 8];
          s_d.all_ones    = s_q.all_ones && rx_data == 8'hff;
          s_d.ucast_match = s_q.ucast_match && rx_data == sta_byte;
        end
        if (s_q.idx == LEN_HI_INDEX - 11'h001) begin
          s_d.len_field[15:8] = rx_data;
        end
        if (s_q.idx == LEN_LO_INDEX - 11'h001) begin
          s_d.len_field[7:0] = rx_data;
          s_d.strip_active   = s_q.pad_strip_enable && {s_q.len_field[15:8], rx_data} < PAD_LIMIT_LEN;
        end
        // Count here so that the hash, strip and runt checks below see the index of this byte.
        if (s_q.idx != BYTE_COUNT_MAX) begin
          s_d.idx = s_q.idx + 11'h001;
        end
      end
      // The hash reuses the running FCS once the destination address is in.
      if (s_d.idx == DA_BYTES - 11'h001 && s_q.in_frame) begin
        s_d.hash_hit = s_q.logical_multicast_filter[crc_next[31:26]];
      end

      keep_bytes = HEADER_BYTES + s_q.len_field[10:0];
      s_d.fifo_data = rx_data;
      s_d.fifo_wr   = !(s_q.strip_active && s_d.idx >= keep_bytes);

      if (rx_last) begin
        runt = s_d.idx < MIN_FRAME_BYTES - 11'h001;
        if (s_q.mode_reg[MODE_PROMISCUOUS]) begin
          accept = 1'b1;
        end else if (s_d.all_ones) begin
          accept = !s_q.mode_reg[MODE_DISABLE_BROADCAST];
        end else if (s_d.multicast) begin
          accept = s_d.hash_hit;
        end else begin
          accept = s_d.ucast_match && !s_q.mode_reg[MODE_DISABLE_UNICAST];
        end
        // Each frame is judged at its own end, so earlier frames in the FIFO play no part.
        s_d.fifo_end  = 1'b1;
        s_d.fifo_keep = accept && !s_d.fragment && !(runt && !s_q.runt_accept_enable);
        s_d.crc_error = crc_next != CRC_RESIDUE;
        s_d.in_frame  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q                          <= '0;
      s_q.waitrequest              <= 1'b1;
      s_q.mode_reg                 <= MODE_RESET;
      s_q.receive_watermark        <= WATERMARK_RESET;
      s_q.crc                      <= CRC_INIT;
      s_q.sqe_state                <= SQ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.readdata;
  assign avs_waitrequest = s_q.waitrequest;
  assign fifo_wr         = s_q.fifo_wr;
  assign fifo_data       = s_q.fifo_data;
  assign fifo_end        = s_q.fifo_end;
  assign fifo_keep       = s_q.fifo_keep;
  assign crc_error       = s_q.crc_error;
  assign drain_request   = s_q.drain_request;
  assign interrupt_out   = s_q.interrupt_out;

endmodule // rx_filter

`default_nettype wire

// *** design/rx_filter_pkg.sv ***
// Constants for the receive filter and collision-test check block.
package rx_filter_pkg;

  // Register byte offsets on the register bus.
  localparam logic [7:0] OFS_MAIN_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] OFS_MODE_REG            = 8'h04;
  localparam logic [7:0] OFS_STATION_LO          = 8'h08;
  localparam logic [7:0] OFS_STATION_HI          = 8'h0c;
  localparam logic [7:0] OFS_FILTER_LO           = 8'h10;
  localparam logic [7:0] OFS_FILTER_HI           = 8'h14;
  localparam logic [7:0] OFS_FEATURE_CONTROL     = 8'h18;
  localparam logic [7:0] OFS_FIFO_THRESHOLD      = 8'h1c;
  localparam logic [7:0] OFS_TEST_FEATURE        = 8'h20;

  // Field positions.
  localparam int MCS_COLLISION_ERROR_BIT = 0;
  localparam int MCS_ERROR_SUMMARY_BIT   = 15;
  localparam int MODE_DISABLE_UNICAST    = 13;
  localparam int MODE_DISABLE_BROADCAST  = 14;
  localparam int MODE_PROMISCUOUS        = 15;
  localparam int FEATURE_PAD_STRIP_BIT   = 0;
  localparam int TEST_RUNT_ACCEPT_BIT    = 3;

  // Reset values.
  localparam logic [15:0] MODE_RESET      = 16'h0000;
  localparam logic [1:0]  WATERMARK_RESET = 2'h2;

  // Receive watermark thresholds in bytes, indexed by the watermark field.
  localparam logic [7:0] WATERMARK_BYTES_0 = 8'h10;
  localparam logic [7:0] WATERMARK_BYTES_1 = 8'h20;
  localparam logic [7:0] WATERMARK_BYTES_2 = 8'h40;
  localparam logic [7:0] WATERMARK_BYTES_3 = 8'h70;

  // Frame geometry in bytes.
  localparam logic [10:0] MIN_FRAME_BYTES   = 11'h040;
  localparam logic [10:0] SLOT_BYTES        = 11'h040;
  localparam logic [10:0] DA_BYTES          = 11'h006;
  localparam logic [10:0] HEADER_BYTES      = 11'h00e;
  localparam logic [10:0] LEN_HI_INDEX      = 11'h00c;
  localparam logic [10:0] LEN_LO_INDEX      = 11'h00d;
  localparam logic [15:0] PAD_LIMIT_LEN     = 16'h002e;
  localparam logic [10:0] BYTE_COUNT_MAX    = 11'h7ff;

  // Frame check sequence.
  localparam logic [31:0] CRC_POLY    = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'hc704dd7b;

  // Collision test window: 40 bit times at 10 Mbit/s, longest time rounds down.
  localparam int CLK_PERIOD_PS       = 40000;
  localparam int BIT_TIME_PS         = 100000;
  localparam int SQE_WINDOW_BITS     = 40;
  localparam int SQE_WINDOW_CYC_INT  = (SQE_WINDOW_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
  localparam logic [7:0] SQE_WINDOW_CYC = SQE_WINDOW_CYC_INT[7:0];

  typedef enum logic [1:0] {
    SQ_IDLE      = 2'b00,
    SQ_TX        = 2'b01,
    SQ_WAIT_IDLE = 2'b10,
    SQ_WINDOW    = 2'b11
  } sqe_state_t;

endpackage : rx_filter_pkg

// *** testbench/medium_model.sv ***
// Behavioural model of the medium side: transmit, loopback carrier and collision test.
`timescale 1ns/10ps
`default_nettype none
module medium_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start_tx,
  input  wire logic sqe_en,
  output logic      tx_active,
  output logic      rx_carrier,
  output logic      sqe_in
);
  logic [7:0] t_q;
  always_ff @(posedge clk) begin
    if (rst || start_tx) begin
      t_q <= {7'h00, start_tx};
    end else if (t_q != 8'h00 && t_q != 8'hff) begin
      t_q <= t_q + 8'h01;
    end
  end
  // The test burst comes seven cycles after carrier drops; sqe_en low models a unit without it.
  assign tx_active  = t_q >= 8'h01 && t_q <= 8'h14;
  assign rx_carrier = t_q >= 8'h02 && t_q <= 8'h16;
  assign sqe_in     = sqe_en && t_q >= 8'h1e && t_q <= 8'h27;
endmodule // medium_model
`default_nettype wire

// *** testbench/rx_filter_checker.sv ***
// Assertion checker for the receive filter block.
`timescale 1ns/10ps
`default_nettype none
module rx_filter_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rx_valid,
  input wire logic        rx_last,
  input wire logic        rx_col,
  input wire logic        fifo_wr,
  input wire logic        fifo_end,
  input wire logic        fifo_keep,
  input wire logic        crc_error,
  input wire logic        interrupt_out
);
  import rx_filter_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [10:0] cnt_q;
  logic        frag_q;
  logic        runt_q;
  // Runt acceptance is shadowed from bus writes because the register is not visible at the ports.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= 11'h000;
      frag_q <= 1'b0;
      runt_q <= 1'b0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == OFS_TEST_FEATURE) begin
        runt_q <= avs_writedata[TEST_RUNT_ACCEPT_BIT];
      end
      if (fifo_end) begin
        cnt_q  <= 11'h000;
        frag_q <= 1'b0;
      end else begin
        if (rx_valid) begin
          cnt_q <= cnt_q + 11'h001;
        end
        if (rx_col && cnt_q < SLOT_BYTES && (rx_valid || cnt_q != 11'h000)) begin
          frag_q <= 1'b1;
        end
      end
    end
  end
  sequence s_last_byte;
    rx_valid && rx_last;
  endsequence
  sequence s_request;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  a_irq_low: assert property (interrupt_out == 1'b0)
    else $error("interrupt output raised");
  a_bus_answer: assert property (s_request |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > OFS_TEST_FEATURE |->
    avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_wr_cause: assert property (fifo_wr |-> $past(rx_valid))
    else $error("fifo write without byte");
  a_end_last: assert property (s_last_byte |=> fifo_end)
    else $error("frame end missing");
  a_frag_drop: assert property (fifo_end && frag_q |-> !fifo_keep)
    else $error("fragment kept");
  a_runt_drop: assert property (fifo_end && cnt_q < MIN_FRAME_BYTES && !runt_q |-> !fifo_keep)
    else $error("runt kept");
  a_status_hold: assert property (!fifo_end |-> $stable(fifo_keep) && $stable(crc_error))
    else $error("frame status moved between ends");
endmodule // rx_filter_checker
bind rx_filter rx_filter_checker u_chk (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_last(rx_last), .rx_col(rx_col),
  .fifo_wr(fifo_wr), .fifo_end(fifo_end), .fifo_keep(fifo_keep), .crc_error(crc_error),
  .interrupt_out(interrupt_out));
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the receive filter block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rx_filter_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_last = 1'b0;
  logic        rx_col = 1'b0;
  logic        fifo_wr, fifo_end, fifo_keep, crc_error, drain_request, interrupt_out;
  logic [7:0]  fifo_data;
  logic [7:0]  fifo_level = 8'h00;
  logic        tx_active, rx_carrier, sqe_in;
  logic        tp_mode = 1'b0;
  logic        link_fail = 1'b0;
  logic        start_tx = 1'b0;
  logic        sqe_en = 1'b1;
  logic [31:0] q;
  logic [7:0]  fr [0:79];
  int          miscompares = 0;
  int          tests_run = 0;
  int          wr_cnt = 0;
  localparam logic [47:0] SA = 48'h665544332210;
  localparam logic [47:0] BC = 48'hffffffffffff;
  localparam logic [47:0] MC = 48'h0000005e0001;
  always #20 clk = ~clk;
  always @(posedge clk) if (fifo_wr === 1'b1) wr_cnt++;
  rx_filter u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_col(rx_col), .fifo_wr(fifo_wr), .fifo_data(fifo_data), .fifo_end(fifo_end), .fifo_keep(fifo_keep),
    .crc_error(crc_error), .fifo_level(fifo_level), .drain_request(drain_request), .tx_active(tx_active),
    .rx_carrier(rx_carrier), .sqe_in(sqe_in), .tp_mode(tp_mode), .link_fail(link_fail),
    .interrupt_out(interrupt_out));
  medium_model u_medium (.clk(clk), .rst(rst), .start_tx(start_tx), .sqe_en(sqe_en),
    .tx_active(tx_active), .rx_carrier(rx_carrier), .sqe_in(sqe_in));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
    if (n >= 50) miscompares++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? CRC_POLY : 32'h0);
    return c;
  endfunction
  // Sends n header and data bytes plus FCS back to back, then checks the frame status and byte count.
  task automatic send(input logic [47:0] da, input int n, input logic [15:0] len, input int col,
                      input logic bad, input logic ek, input logic ec, input int ew);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      fr[i] = (i < 6) ? da[8*i+:8] : (i == 12) ? len[15:8] : (i == 13) ? len[7:0] : 8'(i);
      c = crc_step(c, fr[i]);
    end
    for (int k = 0; k < 4; k++) for (int j = 0; j < 8; j++) fr[n+k][j] = ~c[31-8*k-j];
    fr[n][0] = fr[n][0] ^ bad;
    wr_cnt = 0;
    for (int i = 0; i < n + 4; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= fr[i];
      rx_last <= (i == n + 3);
      rx_col <= (i == col);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_col <= 1'b0;
    #1 chk("fifo_end", 1, fifo_end);
    chk("fifo_data", fr[n + 3], fifo_data);
    chk("fifo_keep", ek, fifo_keep);
    chk("crc_error", ec, crc_error);
    @(posedge clk);
    #1 chk("written bytes", ew, wr_cnt);
  endtask
  task automatic sqe_run(input logic en, input logic [31:0] e);
    sqe_en <= en;
    @(posedge clk);
    start_tx <= 1'b1;
    @(posedge clk);
    start_tx <= 1'b0;
    repeat (150) @(posedge clk);
    bus(0, OFS_MAIN_CONTROL_STATUS, 0);
    chk("control status", e, q);
    chk("interrupt_out", 0, interrupt_out);
    bus(1, OFS_MAIN_CONTROL_STATUS, 32'h1);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #800000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(0, OFS_MODE_REG, 0); chk("mode", 0, q);
    bus(0, OFS_FIFO_THRESHOLD, 0); chk("watermark", 2, q);
    bus(0, 8'h40, 0); chk("unmapped", 0, q);
    fifo_level <= 8'd63; repeat (3) @(posedge clk); chk("drain", 0, drain_request);
    fifo_level <= 8'd64; repeat (3) @(posedge clk); chk("drain", 1, drain_request);
    $display("test registers done");
    bus(1, OFS_STATION_LO, SA[31:0]);
    bus(1, OFS_STATION_HI, {16'h0, SA[47:32]});
    send(SA, 60, 46, -1, 0, 1, 0, 64);
    send(48'h675544332210, 60, 46, -1, 0, 0, 0, 64);
    send(SA, 60, 46, -1, 1, 1, 1, 64);
    bus(1, OFS_MODE_REG, 32'h2000);
    send(SA, 60, 46, -1, 0, 0, 0, 64);
    $display("test unicast done");
    bus(1, OFS_MODE_REG, 0);
    send(BC, 60, 46, -1, 0, 1, 0, 64);
    bus(1, OFS_MODE_REG, 32'h4000);
    send(BC, 60, 46, -1, 0, 0, 0, 64);
    bus(1, OFS_MODE_REG, 32'he000);
    send(BC, 60, 46, -1, 0, 1, 0, 64);
    send(48'h665544332212, 60, 46, -1, 0, 1, 0, 64);
    send(SA, 36, 46, -1, 0, 0, 0, 40);
    bus(1, OFS_MODE_REG, 0);
    $display("test broadcast done");
    send(MC, 60, 46, -1, 0, 0, 0, 64);
    q = CRC_INIT;
    for (int i = 0; i < 6; i++) q = crc_step(q, MC[8*i+:8]);
    bus(1, q[31] ? OFS_FILTER_HI : OFS_FILTER_LO, 32'h1 << q[30:26]);
    send(MC, 60, 46, -1, 0, 1, 0, 64);
    $display("test multicast done");
    bus(1, OFS_FEATURE_CONTROL, 32'h1);
    send(SA, 60, 10, -1, 0, 1, 0, 24);
    send(SA, 60, 46, -1, 0, 1, 0, 64);
    bus(1, OFS_FEATURE_CONTROL, 0);
    $display("test pad strip done");
    send(SA, 36, 46, -1, 0, 0, 0, 40);
    send(SA, 60, 46, 20, 0, 0, 0, 64);
    bus(1, OFS_TEST_FEATURE, 32'h8);
    send(SA, 36, 46, -1, 0, 1, 0, 40);
    bus(1, OFS_TEST_FEATURE, 0);
    $display("test fragments done");
    sqe_run(1, 0);
    sqe_run(0, 32'h8001);
    tp_mode <= 1'b1;
    link_fail <= 1'b1;
    sqe_run(1, 32'h8001);
    link_fail <= 1'b0;
    sqe_run(0, 0);
    $display("test collision check done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
